//--- core/crt_raster_timing_controller.sv
// Raster timing controller: host register file, counters and video outputs
`timescale 1ns/10ps
module crt_raster_timing_controller
  import crt_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic device_clear_n_i,
  input wire logic pen_strobe_i,
  input wire logic bus_strobe_i,
  input wire logic chip_sel_n_i,
  input wire logic register_select_i,
  input wire logic rd_wr_n_i,
  input wire logic [7:0] host_data_i,
  output logic [7:0] host_data_o,
  output logic host_data_oe_n_o,
  output logic horizontal_sync_out_o,
  output logic vertical_sync_out_o,
  output logic disp_en_o,
  output logic cursor_o,
  output logic [13:0] refresh_addr_o,
  output logic [4:0] row_line_addr_o,
  output logic test_mode_o
);

  // Whole module state in one record
  typedef struct packed {
    logic [1:0] clr_s;
    logic [1:0] pen_s;
    logic [1:0] stb_s;
    logic pen_prev;
    logic stb_prev;
    crt_bus_t bus_s1;
    crt_bus_t bus_s2;
    logic [4:0] ptr;
    crt_regs_t regs;
    crt_timing_t tim;
    crt_video_t vid;
    logic [7:0] rdata;
    logic rd_act;
  } crt_state_t;

  crt_state_t s_q;
  crt_state_t s_d;
  crt_bus_t bus_in;
  logic clear_act;
  logic pen_rise;
  logic stb_fall;
  logic line_end;
  logic row_end;
  logic frame_end;
  logic vsync_start;
  logic [4:0] row_addr;
  logic [7:0] rd_mux;

  assign bus_in = '{strobe: bus_strobe_i, chip_sel_n: chip_sel_n_i,
                    register_select: register_select_i,
                    rd_wr_n: rd_wr_n_i, host_data: host_data_i};

  // Clear counts only while the pen strobe is low; pen high means test
  assign clear_act = ~s_q.clr_s[1] & ~s_q.pen_s[1];
  assign test_mode_o = ~s_q.clr_s[1] & s_q.pen_s[1];
  assign pen_rise = s_q.pen_s[1] & ~s_q.pen_prev;
  // Strobe active edge is high to low, sampled after synchronising
  assign stb_fall = s_q.stb_prev & ~s_q.stb_s[1];

  // Horizontal wrap gives exactly one line-end pulse
  assign line_end = (s_q.tim.hcnt == s_q.regs.horizontal_total_setting);
  // Raster coincidence with max scan closes a character row
  assign row_end = line_end & ~s_q.tim.in_adj &
                   (s_q.tim.rcnt == s_q.regs.maxscan);
  // Frame ends after last whole row, or after adjust lines when set
  assign frame_end = s_q.tim.in_adj ?
      (line_end & (s_q.tim.adjcnt == s_q.regs.vertical_adjust_setting)) :
      (row_end & (s_q.tim.vcnt == s_q.regs.vertical_total_setting) &
       (s_q.regs.vertical_adjust_setting == 5'h00));
  assign vsync_start = row_end &
      ((s_q.tim.vcnt + 7'h01) == s_q.regs.vspos);

  // Interlace sync-and-video scans alternate lines per field
  always_comb begin
    if (s_q.regs.ilace == ILACE_SYNC_VIDEO) begin
      row_addr = {s_q.tim.rcnt[3:0], s_q.tim.field};
    end else begin
      row_addr = s_q.tim.rcnt;
    end
  end

  // Read mux: only cursor and pen capture read back, others read zero
  always_comb begin
    unique case (s_q.ptr)
      REG_CURH: rd_mux = {2'h0, s_q.regs.cursor_addr[13:8]};
      REG_CURL: rd_mux = s_q.regs.cursor_addr[7:0];
      REG_PENH: rd_mux = {2'h0, s_q.regs.pen_addr[13:8]};
      REG_PENL: rd_mux = s_q.regs.pen_addr[7:0];
      default: rd_mux = 8'h00;
    endcase
  end

  // Next-state logic for the whole block
  always_comb begin
    s_d = s_q;
    s_d.clr_s = {s_q.clr_s[0], device_clear_n_i};
    s_d.pen_s = {s_q.pen_s[0], pen_strobe_i};
    s_d.stb_s = {s_q.stb_s[0], bus_strobe_i};
    s_d.pen_prev = s_q.pen_s[1];
    s_d.stb_prev = s_q.stb_s[1];
    // Bus fields pass two stages so they align with the strobe edge
    s_d.bus_s1 = bus_in;
    s_d.bus_s2 = s_q.bus_s1;

    // Drive window follows a selected read while strobe is high
    s_d.rd_act = s_q.stb_s[1] & ~s_q.bus_s2.chip_sel_n &
                 s_q.bus_s2.rd_wr_n & s_q.bus_s2.register_select;
    s_d.rdata = rd_mux;

    // Register writes; a clear does not touch them
    if (stb_fall && !s_q.bus_s2.chip_sel_n &&
        !s_q.bus_s2.rd_wr_n) begin
      if (!s_q.bus_s2.register_select) begin
        s_d.ptr = s_q.bus_s2.host_data[4:0];
      end else begin
        unique case (s_q.ptr)
          REG_HTOTAL: s_d.regs.horizontal_total_setting =
                        s_q.bus_s2.host_data;
          REG_HDISP: s_d.regs.hdisp = s_q.bus_s2.host_data;
          REG_HSPOS: s_d.regs.hspos = s_q.bus_s2.host_data;
          REG_HSWID: s_d.regs.hswid = s_q.bus_s2.host_data[3:0];
          REG_VTOTAL: s_d.regs.vertical_total_setting =
                        s_q.bus_s2.host_data[6:0];
          REG_VADJ: s_d.regs.vertical_adjust_setting =
                      s_q.bus_s2.host_data[4:0];
          REG_VDISP: s_d.regs.vdisp = s_q.bus_s2.host_data[6:0];
          REG_VSPOS: s_d.regs.vspos = s_q.bus_s2.host_data[6:0];
          REG_ILACE: s_d.regs.ilace = s_q.bus_s2.host_data[1:0];
          REG_MAXSCAN: s_d.regs.maxscan = s_q.bus_s2.host_data[4:0];
          REG_CURSTART: s_d.regs.curstart = s_q.bus_s2.host_data[6:0];
          REG_CUREND: s_d.regs.curend = s_q.bus_s2.host_data[4:0];
          REG_STARTH: s_d.regs.start_addr[13:8] =
                        s_q.bus_s2.host_data[5:0];
          REG_STARTL: s_d.regs.start_addr[7:0] = s_q.bus_s2.host_data;
          REG_CURH: s_d.regs.cursor_addr[13:8] =
                      s_q.bus_s2.host_data[5:0];
          REG_CURL: s_d.regs.cursor_addr[7:0] = s_q.bus_s2.host_data;
          default: s_d.ptr = s_q.ptr;
        endcase
      end
    end

    // Pen capture of the live refresh address
    if (pen_rise) begin
      s_d.regs.pen_addr = s_q.tim.ma;
    end

    if (clear_act) begin
      // Counters cleared and display halted while clear holds
      s_d.tim = '0;
      s_d.vid = '0;
    end else begin
      // Horizontal counter and linear address step each character
      s_d.tim.hcnt = line_end ? 8'h00 : s_q.tim.hcnt + 8'h01;
      s_d.tim.ma = s_q.tim.ma + 14'h0001;
      // Horizontal sync from position compare, programmed width
      if (s_q.tim.hcnt == s_q.regs.hspos) begin
        s_d.tim.hsync = 1'b1;
        s_d.tim.hswcnt = 4'h0;
      end else if (s_q.tim.hsync) begin
        s_d.tim.hswcnt = s_q.tim.hswcnt + 4'h1;
        if (s_q.tim.hswcnt + 4'h1 == s_q.regs.hswid) begin
          s_d.tim.hsync = 1'b0;
        end
      end
      if (line_end) begin
        // Same address run for each raster of a row
        s_d.tim.ma = s_q.tim.row_base;
        s_d.tim.rcnt = s_q.tim.rcnt + 5'h01;
        if (s_q.tim.in_adj) begin
          s_d.tim.adjcnt = s_q.tim.adjcnt + 5'h01;
        end
        // Vertical sync counts out a fixed line total
        if (s_q.tim.vsync) begin
          s_d.tim.vswcnt = s_q.tim.vswcnt + 4'h1;
          if (s_q.tim.vswcnt == VSYNC_LAST) begin
            s_d.tim.vsync = 1'b0;
          end
        end
      end
      if (row_end) begin
        s_d.tim.rcnt = 5'h00;
        s_d.tim.vcnt = s_q.tim.vcnt + 7'h01;
        // Row base moves on only at a row boundary, so rasters repeat
        s_d.tim.row_base = s_q.tim.row_base + {6'h00, s_q.regs.hdisp};
        s_d.tim.ma = s_q.tim.row_base + {6'h00, s_q.regs.hdisp};
        if (s_q.tim.vcnt == s_q.regs.vertical_total_setting) begin
          s_d.tim.in_adj = 1'b1;
          s_d.tim.adjcnt = 5'h01;
        end
      end
      if (vsync_start) begin
        s_d.tim.vsync = 1'b1;
        s_d.tim.vswcnt = 4'h0;
      end
      if (frame_end) begin
        // New frame restarts at the scroll origin
        s_d.tim.vcnt = 7'h00;
        s_d.tim.rcnt = 5'h00;
        s_d.tim.in_adj = 1'b0;
        s_d.tim.adjcnt = 5'h00;
        s_d.tim.ma = s_q.regs.start_addr;
        s_d.tim.row_base = s_q.regs.start_addr;
        s_d.tim.field = ~s_q.tim.field;
        s_d.tim.fcnt = s_q.tim.fcnt + 5'h01;
      end
      // Registered video outputs, one clock behind the counters
      s_d.vid.horizontal_sync_out = s_q.tim.hsync;
      s_d.vid.vertical_sync_out = s_q.tim.vsync;
      s_d.vid.disp_en = (s_q.tim.hcnt < s_q.regs.hdisp) &
                        (s_q.tim.vcnt < s_q.regs.vdisp) &
                        ~s_q.tim.in_adj;
      s_d.vid.refresh_addr = s_q.tim.ma;
      s_d.vid.row_line_addr = row_addr;
      // Cursor when address matches inside its raster band
      s_d.vid.cursor = (s_q.tim.ma == s_q.regs.cursor_addr) &
                       (s_q.tim.rcnt >= s_q.regs.curstart[4:0]) &
                       (s_q.tim.rcnt <= s_q.regs.curend) &
                       (s_q.tim.hcnt < s_q.regs.hdisp) &
                       ~s_q.tim.in_adj;
    end
  end

  // Whole state registered on falling clock edge; settings survive clear
  always_ff @(negedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign horizontal_sync_out_o = s_q.vid.horizontal_sync_out;
  assign vertical_sync_out_o = s_q.vid.vertical_sync_out;
  assign disp_en_o = s_q.vid.disp_en;
  assign cursor_o = s_q.vid.cursor;
  assign refresh_addr_o = s_q.vid.refresh_addr;
  assign row_line_addr_o = s_q.vid.row_line_addr;
  assign host_data_o = s_q.rdata;
  // Released to high impedance except during a selected read
  assign host_data_oe_n_o = ~s_q.rd_act;

endmodule : crt_raster_timing_controller

//--- core/crt_pkg.sv
// Package of constants and carrier types for the raster timing controller
package crt_pkg;
  // Register indices reached through the indirect pointer
  localparam logic [4:0] REG_HTOTAL = 5'h00;
  localparam logic [4:0] REG_HDISP = 5'h01;
  localparam logic [4:0] REG_HSPOS = 5'h02;
  localparam logic [4:0] REG_HSWID = 5'h03;
  localparam logic [4:0] REG_VTOTAL = 5'h04;
  localparam logic [4:0] REG_VADJ = 5'h05;
  localparam logic [4:0] REG_VDISP = 5'h06;
  localparam logic [4:0] REG_VSPOS = 5'h07;
  localparam logic [4:0] REG_ILACE = 5'h08;
  localparam logic [4:0] REG_MAXSCAN = 5'h09;
  localparam logic [4:0] REG_CURSTART = 5'h0a;
  localparam logic [4:0] REG_CUREND = 5'h0b;
  localparam logic [4:0] REG_STARTH = 5'h0c;
  localparam logic [4:0] REG_STARTL = 5'h0d;
  localparam logic [4:0] REG_CURH = 5'h0e;
  localparam logic [4:0] REG_CURL = 5'h0f;
  localparam logic [4:0] REG_PENH = 5'h10;
  localparam logic [4:0] REG_PENL = 5'h11;
  // Fixed vertical sync width in raster lines, minus one
  localparam logic [3:0] VSYNC_LAST = 4'hf;
  // Interlace field layout: sync-and-video mode uses both low bits
  localparam logic [1:0] ILACE_SYNC_VIDEO = 2'h3;

  // Programmable settings, kept through clear, zeroed by reset
  typedef struct packed {
    logic [7:0] horizontal_total_setting;
    logic [7:0] hdisp;
    logic [7:0] hspos;
    logic [3:0] hswid;
    logic [6:0] vertical_total_setting;
    logic [4:0] vertical_adjust_setting;
    logic [6:0] vdisp;
    logic [6:0] vspos;
    logic [1:0] ilace;
    logic [4:0] maxscan;
    logic [6:0] curstart;
    logic [4:0] curend;
    logic [13:0] start_addr;
    logic [13:0] cursor_addr;
    logic [13:0] pen_addr;
  } crt_regs_t;

  // Raster timing state, cleared by reset
  typedef struct packed {
    logic [7:0] hcnt;
    logic [4:0] rcnt;
    logic [6:0] vcnt;
    logic in_adj;
    logic [4:0] adjcnt;
    logic [3:0] hswcnt;
    logic hsync;
    logic [3:0] vswcnt;
    logic vsync;
    logic field;
    logic [13:0] row_base;
    logic [13:0] ma;
    logic [4:0] fcnt;
  } crt_timing_t;

  // Host bus inputs taken together
  typedef struct packed {
    logic strobe;
    logic chip_sel_n;
    logic register_select;
    logic rd_wr_n;
    logic [7:0] host_data;
  } crt_bus_t;

  // Video outputs taken together
  typedef struct packed {
    logic horizontal_sync_out;
    logic vertical_sync_out;
    logic disp_en;
    logic cursor;
    logic [13:0] refresh_addr;
    logic [4:0] row_line_addr;
  } crt_video_t;
endpackage : crt_pkg

//--- tb/crt_rtc_checker.sv
// Port checker for the raster timing controller
`timescale 1ns/10ps
module crt_rtc_checker
  import crt_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic device_clear_n_i,
  input wire logic pen_strobe_i,
  input wire logic chip_sel_n_i,
  input wire logic register_select_i,
  input wire logic rd_wr_n_i,
  input wire logic host_data_oe_n_o,
  input wire logic horizontal_sync_out_o,
  input wire logic vertical_sync_out_o,
  input wire logic disp_en_o,
  input wire logic cursor_o,
  input wire logic [13:0] refresh_addr_o,
  input wire logic [4:0] row_line_addr_o,
  input wire logic test_mode_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  logic hs_q;
  logic [4:0] vs_lines_q;
  // Count line syncs inside a frame pulse; sampled mid-cycle when settled
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hs_q <= 1'b0;
      vs_lines_q <= 5'h00;
    end else begin
      hs_q <= horizontal_sync_out_o;
      if (!vertical_sync_out_o)
        vs_lines_q <= 5'h00;
      else if (horizontal_sync_out_o && !hs_q)
        vs_lines_q <= vs_lines_q + 5'h01;
    end
  end
  sequence s_clr;
    (!device_clear_n_i && !pen_strobe_i) [*5];
  endsequence
  a_oe_read_only: assert property (!host_data_oe_n_o |->
    !$past(chip_sel_n_i, 2) && $past(rd_wr_n_i, 2)
    && $past(register_select_i, 2)) else $error("bus driven off a read");
  a_cs_idle_quiet: assert property (chip_sel_n_i [*6] |->
    host_data_oe_n_o) else $error("bus driven while deselected");
  a_clear_all_low: assert property (s_clr |-> refresh_addr_o == 14'h0
    && row_line_addr_o == 5'h0 && !(horizontal_sync_out_o
    || vertical_sync_out_o || disp_en_o || cursor_o || test_mode_o))
    else $error("outputs not low in clear");
  a_test_mode_on: assert property ((!device_clear_n_i && pen_strobe_i)
    [*5] |-> test_mode_o) else $error("test mode missing");
  a_test_mode_off: assert property (device_clear_n_i [*5] |->
    !test_mode_o) else $error("test mode outside clear");
  a_vsync_sixteen: assert property ($fell(vertical_sync_out_o) |->
    vs_lines_q == 5'h10) else $error("frame sync width wrong");
  a_addr_steps: assert property (disp_en_o && $past(disp_en_o) |->
    refresh_addr_o == $past(refresh_addr_o) + 14'h1)
    else $error("refresh address not stepping");
  a_row_held: assert property (disp_en_o && $past(disp_en_o) |->
    $stable(row_line_addr_o)) else $error("row changed inside line");
  a_restart_now: assert property (s_clr ##1 device_clear_n_i [*8] |->
    refresh_addr_o != 14'h0) else $error("display idle after clear");
endmodule : crt_rtc_checker
bind crt_raster_timing_controller crt_rtc_checker crt_rtc_checker_inst (.*);

//--- tb/crt_host_model.sv
// Host bus partner driving the strobed register interface
`timescale 1ns/10ps
module crt_host_model (
  input wire logic clk_i,
  input wire logic oe_n_i,
  input wire logic [7:0] rdata_i,
  output logic strobe_o,
  output logic cs_n_o,
  output logic rs_o,
  output logic rw_o,
  output logic [7:0] wdata_o
);
  // Idle bus: deselected, strobe low
  initial begin
    strobe_o = 1'b0;
    cs_n_o = 1'b1;
    rs_o = 1'b0;
    rw_o = 1'b1;
    wdata_o = 8'h00;
  end
  // One transfer; long phases cover the two-stage input delay
  task automatic access(input logic cs_n, rs, rw, input logic [7:0] d,
                        output logic [8:0] q);
    @(posedge clk_i);
    cs_n_o <= cs_n;
    rs_o <= rs;
    rw_o <= rw;
    wdata_o <= d;
    strobe_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    q = {oe_n_i, rdata_i};
    strobe_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    cs_n_o <= 1'b1;
    rw_o <= 1'b1;
    wdata_o <= ~d; // Released lines keep no stale value
  endtask : access
endmodule : crt_host_model

//--- tb/crt_raster_timing_controller_test.sv
// Self-checking bench for the raster timing controller
`timescale 1ns/10ps
module crt_raster_timing_controller_test
  import crt_pkg::*;
();
  localparam logic [7:0] HD = 8'h0c;
  localparam logic [7:0] CFG [10] = '{8'h13, HD, 8'h0e, 8'h03, 8'h07,
    8'h02, 8'h03, 8'h04, 8'h00, 8'h03};
  logic clk, rstn, clr_n, pen, stb, cs_n, rs, rw, oe_n;
  logic hs, vs, de, cur, tm, pv;
  logic [7:0] wd, rdat;
  logic [13:0] ma, a0;
  logic [4:0] ra;
  logic [5:0] hi;
  logic [8:0] q;
  logic [15:0] lf;
  int err_count, cmp_count, nh, nd, nv;
  crt_raster_timing_controller crt_raster_timing_controller_inst (
    .clk_sys_i(clk), .rstn_i(rstn), .device_clear_n_i(clr_n),
    .pen_strobe_i(pen), .bus_strobe_i(stb), .chip_sel_n_i(cs_n),
    .register_select_i(rs), .rd_wr_n_i(rw), .host_data_i(wd),
    .host_data_o(rdat), .host_data_oe_n_o(oe_n),
    .horizontal_sync_out_o(hs), .vertical_sync_out_o(vs), .disp_en_o(de),
    .cursor_o(cur), .refresh_addr_o(ma), .row_line_addr_o(ra),
    .test_mode_o(tm));
  crt_host_model crt_host_model_inst (.clk_i(clk), .oe_n_i(oe_n),
    .rdata_i(rdat), .strobe_o(stb), .cs_n_o(cs_n), .rs_o(rs), .rw_o(rw),
    .wdata_o(wd));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Row base advances by the displayed count once per character row
  function automatic logic [15:0] exp_ma(input logic [13:0] b, input int l);
    return {2'h0, b + 14'((l / 4) * HD)};
  endfunction : exp_ma
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] idx, input logic [7:0] v);
    crt_host_model_inst.access(1'b0, 1'b0, 1'b0, {3'h0, idx}, q);
    crt_host_model_inst.access(1'b0, 1'b1, 1'b0, v, q);
  endtask : wr
  task automatic rd(input logic [4:0] idx);
    crt_host_model_inst.access(1'b0, 1'b0, 1'b0, {3'h0, idx}, q);
    crt_host_model_inst.access(1'b0, 1'b1, 1'b1, 8'h00, q);
  endtask : rd
  // Bounded wait for a rising edge of the selected output (falling edge of vsync for sel 2)
  task automatic wait_rise(input int sel);
    logic p;
    logic c;
    p = 1'b1;
    for (int n = 0; n < 3000; n++) begin
      @(posedge clk);
      c = (sel == 0) ? hs : (sel == 1) ? vs : (sel == 2) ? !vs : de;
      if (c === 1'b1 && p === 1'b0)
        return;
      p = c;
    end
    err_count++;
    summarize();
  endtask : wait_rise
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Run is near 4k cycles; allow over seven times that
  initial begin
    #3000000;
    err_count++;
    summarize();
  end
  initial begin
    rstn = 1'b0;
    clr_n = 1'b1;
    pen = 1'b0;
    lf = 16'h38e3;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 10; i++)
      wr(5'(i), CFG[i]);
    for (int i = 0; i < 3; i++) begin
      lf = lfsr(lf);
      wr(REG_CURH, lf[15:8]);
      wr(REG_CURL, lf[7:0]);
      rd(REG_CURH);
      chk({7'h0, q}, {10'h0, lf[13:8]});
      rd(REG_CURL);
      chk({7'h0, q}, {8'h0, lf[7:0]});
    end
    hi = lf[13:8];
    // Deselected write and read, pointer read, write-only read
    crt_host_model_inst.access(1'b1, 1'b1, 1'b0, ~lf[7:0], q);
    crt_host_model_inst.access(1'b1, 1'b1, 1'b1, 8'h00, q);
    chk({15'h0, q[8]}, 16'h0001);
    crt_host_model_inst.access(1'b0, 1'b0, 1'b1, 8'h00, q);
    chk({15'h0, q[8]}, 16'h0001);
    rd(REG_HTOTAL);
    chk({7'h0, q}, 16'h0000);
    // Line timing across a displayed line
    wait_rise(2);
    wait_rise(3);
    wait_rise(0);
    nh = 0;
    nd = 0;
    repeat (20) begin
      nh += int'(hs);
      nd += int'(de);
      pv = hs;
      @(posedge clk);
    end
    chk(16'(nh), 16'h0003);
    chk(16'(nd), {8'h0, HD});
    chk({14'h0, pv, hs}, 16'h0001);
    // Frame length includes adjust lines; sync spans sixteen lines
    wait_rise(1);
    nv = 0;
    repeat (34) begin
      wait_rise(0);
      nv += int'(vs);
    end
    chk(16'(nv), 16'h0010);
    chk({15'h0, vs}, 16'h0000);
    wait_rise(0);
    chk({15'h0, vs}, 16'h0001);
    // Scroll start and rows repeating per scan line
    lf = lfsr(lf);
    wr(REG_STARTH, {2'h0, lf[13:8]});
    wr(REG_STARTL, lf[7:0]);
    wait_rise(2);
    for (int i = 0; i < 5; i++) begin
      wait_rise(3);
      chk({2'h0, ma}, exp_ma(lf[13:0], i));
      chk({11'h0, ra}, 16'(i % 4));
    end
    // Clear with pen low, then test mode, then release
    wait_rise(2);
    clr_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk({6'h0, tm, hs, vs, de, cur, ra}, 16'h0000);
    chk({2'h0, ma}, 16'h0000);
    pen <= 1'b1;
    repeat (8) @(posedge clk);
    chk({15'h0, tm}, 16'h0001);
    pen <= 1'b0;
    repeat (8) @(posedge clk);
    clr_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk({15'h0, ma !== 14'h0}, 16'h0001);
    rd(REG_STARTL);
    chk({7'h0, q}, 16'h0000);
    rd(REG_CURH);
    chk({7'h0, q}, {10'h0, hi});
    // Pen capture just after a displayed line starts
    wait_rise(2);
    wait_rise(3);
    a0 = ma;
    pen <= 1'b1;
    repeat (8) @(posedge clk);
    pen <= 1'b0;
    rd(REG_PENH);
    hi = q[5:0];
    rd(REG_PENL);
    chk({15'h0, ({hi, q[7:0]} - a0) <= 14'h6}, 16'h0001);
    summarize();
  end
endmodule : crt_raster_timing_controller_test
